//--- peripheral_write_protect_ctrl_bench.sv
// self-checking bench for the write-protect controller
`timescale 1ns/1ps
`include "pwp_regs.svh"
module peripheral_write_protect_ctrl_bench import pwp_pkg::*;;
	logic i_clk, i_reset_n, psel, penable, pwrite, pready, pslverr, er;
	logic ev, tch, dac, cmp, adc;
	logic [11:0] paddr;
	logic [7:0] tmr;
	logic [5:0] ser;
	pwp_word_t pwdata, prdata, rd, ex;
	int err_count = 0;
	int checks_done = 0;
	wire logic [31:0] outs = {12'h000, tch, dac, cmp, adc, tmr, ser, ev, 1'b0};

	pwp_top i_pwp_top (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_psel(psel), .i_penable(penable),
		.i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(4'hf), .o_pready(pready),
		.o_prdata(prdata), .o_pslverr(pslverr), .o_timer_counter_protect(tmr), .o_serial_module_protect(ser),
		.o_touch_ctrl_protect(tch), .o_dac_protect(dac), .o_comparator_protect(cmp),
		.o_adc_protect(adc), .o_event_system_protect(ev));

	initial begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic conclude();
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : conclude

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	// bounded wait: a slave that never answers ends the run
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge i_clk);
		psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge i_clk);
		penable <= 1'b1;
		do begin
			@(posedge i_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			err_count++;
			conclude();
		end else begin
			rd = prdata;
			er = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask : apb

	// both registers and the protect outputs must agree with the expected state
	task automatic st(input logic [31:0] exp);
		apb(1'b0, `PWP_OFF_CLEAR, 32'h0);
		chk(rd, exp);
		apb(1'b0, `PWP_OFF_SET, 32'h0);
		chk(rd, exp);
		chk({31'h0, er}, 32'h0);
		chk(outs, exp & 32'h000f_fffe);
	endtask : st

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		st(32'h0080_0000);
		$display("test reset done");
	endtask : t_reset

	task automatic t_set_clear();
		apb(1'b1, `PWP_OFF_SET, 32'hffff_ffff);
		ex = 32'h008f_fffe;
		st(ex);
		for (int k = 1; k < 20; k++) begin
			ex[k] = 1'b0;
			apb(1'b1, `PWP_OFF_CLEAR, 32'h1 << k);
			st(ex);
		end
		apb(1'b1, `PWP_OFF_SET, 32'h0022_0004);
		st(32'h0082_0004);
		apb(1'b1, `PWP_OFF_SET, 32'h0);
		apb(1'b1, `PWP_OFF_CLEAR, 32'h0);
		st(32'h0082_0004);
		$display("test set clear done");
	endtask : t_set_clear

	// unmapped places refuse and leave the state alone
	task automatic t_unmapped();
		apb(1'b1, 12'h008, 32'hffff_ffff);
		chk({31'h0, er}, 32'h1);
		apb(1'b0, 12'h00c, 32'h0);
		chk({31'h0, er}, 32'h1);
		chk(rd, 32'h0);
		st(32'h0082_0004);
		$display("test unmapped done");
	endtask : t_unmapped

	initial begin
		i_reset_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0;
		repeat (2) @(posedge i_clk);
		i_reset_n <= 1'b1;
		t_reset();
		t_set_clear();
		t_unmapped();
		conclude();
	end
endmodule : peripheral_write_protect_ctrl_bench

//--- pwp_pkg.sv
// types shared by the write-protect controller
package pwp_pkg;

	typedef logic [31:0] pwp_word_t;

	// decoded register target, one-hot
	typedef enum logic [2:0] {
		PWP_SEL_NONE = 3'b001,
		PWP_SEL_CLEAR = 3'b010,
		PWP_SEL_SET = 3'b100
	} pwp_sel_t;

endpackage : pwp_pkg

//--- pwp_regs.svh
// register offsets, field positions and reset values of the write-protect controller
//
// Overview of operation
// RULE1: a zero written to either register leaves that protection bit unchanged.
// RULE2: a one written to the clear register unprotects only that peripheral.
// RULE3: a protection bit reads one while protected, zero while unprotected.
// RULE4: bits 15..8 timers 7..0; 19 touch, 18 dac, 17 comparator, 16 adc, 1 events.
// RULE5: bits 7..2 serial modules 5..0; bit 0 and bits 31..20 protect nothing.
// RULE6: set register at offset 0x04, resets to 0x00800000, same layout as clear.
// RULE7: clear register at offset 0x00, resets to 0x00800000.
// RULE8: a one written to set protects that peripheral; both registers read shared state.
`ifndef PWP_REGS_SVH
`define PWP_REGS_SVH

`define PWP_OFF_CLEAR 12'h000
`define PWP_OFF_SET 12'h004
`define PWP_RESET_VAL 32'h0080_0000
`define PWP_WRITE_MASK 32'h000f_fffe

`define PWP_EVENT_BIT 1
`define PWP_SERIAL_LSB 2
`define PWP_SERIAL_MSB 7
`define PWP_TIMER_LSB 8
`define PWP_TIMER_MSB 15
`define PWP_ADC_BIT 16
`define PWP_COMPARATOR_BIT 17
`define PWP_DAC_BIT 18
`define PWP_TOUCH_BIT 19

`endif

//--- pwp_top.sv
// apb slave holding the peripheral write-protection state
//
// Implementation choice: register access over APB.
`timescale 1ns/1ps
`include "pwp_regs.svh"

module pwp_top
	import pwp_pkg::*;
#(
	parameter int ADDR_W = 12
) (
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [ADDR_W-1:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic [3:0] i_pstrb,
	output logic o_pready,
	output logic [31:0] o_prdata,
	output logic o_pslverr,
	output logic [7:0] o_timer_counter_protect,
	output logic [5:0] o_serial_module_protect,
	output logic o_touch_ctrl_protect,
	output logic o_dac_protect,
	output logic o_comparator_protect,
	output logic o_adc_protect,
	output logic o_event_system_protect
);

	////////////////////////////////////////////////////////////////////////////
	// address decode

	pwp_sel_t sel;
	pwp_word_t prot_q;
	pwp_word_t wmask;
	logic pready_q;
	logic pslverr_q;
	pwp_word_t prdata_q;
	logic access;
	logic done;
	logic wr_clear;
	logic wr_set;

	always_comb begin
		case (i_paddr)
			ADDR_W'(`PWP_OFF_CLEAR): sel = PWP_SEL_CLEAR; // RULE7
			ADDR_W'(`PWP_OFF_SET): sel = PWP_SEL_SET; // RULE6
			default: sel = PWP_SEL_NONE;
		endcase
	end

	// byte strobes gate the write so a narrow write cannot touch other lanes
	always_comb begin
		wmask = pwp_word_t'(`PWP_WRITE_MASK); // RULE5
		for (int b = 0; b < 4; b++) begin
			if (!i_pstrb[b]) begin
				wmask[b*8 +: 8] = 8'h00;
			end
		end
	end

	assign access = i_psel && i_penable;
	assign done = access && pready_q;
	assign wr_clear = done && i_pwrite && (sel == PWP_SEL_CLEAR);
	assign wr_set = done && i_pwrite && (sel == PWP_SEL_SET);

	////////////////////////////////////////////////////////////////////////////
	// apb handshake: one wait state, answer on the second access cycle

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			pready_q <= 1'b0;
		end else begin
			pready_q <= access && !pready_q;
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			pslverr_q <= 1'b0;
		end else begin
			pslverr_q <= access && !pready_q && (sel == PWP_SEL_NONE);
		end
	end

	// read data captured one cycle before pready; no write can land in between
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			prdata_q <= 32'h0000_0000;
		end else if (access && !pready_q) begin
			if (!i_pwrite && (sel != PWP_SEL_NONE)) begin
				prdata_q <= prot_q; // RULE3 RULE8
			end else begin
				prdata_q <= 32'h0000_0000;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// shared protection state

	// bit 23 keeps its reset one forever: it is outside the writable mask
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			prot_q <= pwp_word_t'(`PWP_RESET_VAL); // RULE6 RULE7
		end else if (wr_clear) begin
			prot_q <= prot_q & ~(i_pwdata & wmask); // RULE1 RULE2
		end else if (wr_set) begin
			prot_q <= prot_q | (i_pwdata & wmask); // RULE1 RULE8
		end
	end

	assign o_pready = pready_q;
	assign o_pslverr = pslverr_q;
	assign o_prdata = prdata_q;

	// protect outputs are slices of the state flop
	assign o_timer_counter_protect = prot_q[`PWP_TIMER_MSB:`PWP_TIMER_LSB]; // RULE4
	assign o_serial_module_protect = prot_q[`PWP_SERIAL_MSB:`PWP_SERIAL_LSB]; // RULE5
	assign o_touch_ctrl_protect = prot_q[`PWP_TOUCH_BIT]; // RULE4
	assign o_dac_protect = prot_q[`PWP_DAC_BIT]; // RULE4
	assign o_comparator_protect = prot_q[`PWP_COMPARATOR_BIT]; // RULE4
	assign o_adc_protect = prot_q[`PWP_ADC_BIT]; // RULE4
	assign o_event_system_protect = prot_q[`PWP_EVENT_BIT]; // RULE4

	////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_reset_n);

	sequence s_access_start;
		i_psel && i_penable && !pready_q;
	endsequence

	sequence s_answer;
		##1 pready_q;
	endsequence

	answer_timing_a: assert property (s_access_start |-> s_answer) // no RULE: APB handshake timing
		else $error("pready not given one cycle into access");

	zero_write_a: assert property ((wr_clear || wr_set) && (i_pwdata == 32'h0000_0000) |=> $stable(prot_q)) // RULE1
		else $error("zero write changed protection");

	clear_write_a: assert property (wr_clear |=> prot_q == ($past(prot_q) & ~($past(i_pwdata) & $past(wmask)))) // RULE2
		else $error("clear write wrong");

	read_state_a: assert property (done && !i_pwrite && !pslverr_q |-> prdata_q == prot_q) // RULE3
		else $error("read data differs from protection state");

	timer_map_a: assert property (o_timer_counter_protect == prot_q[15:8] && o_touch_ctrl_protect == prot_q[19]) // RULE4
		else $error("timer or touch mapping wrong");

	unused_bits_a: assert property (prot_q[0] == 1'b0 && prot_q[31:24] == 8'h00 && prot_q[22:20] == 3'b000) // RULE5
		else $error("unused protection bit set");

	set_offset_a: assert property (wr_set |-> i_paddr == ADDR_W'(`PWP_OFF_SET) && prot_q[23]) // RULE6
		else $error("set decode or reset bit wrong");

	clear_offset_a: assert property (wr_clear |-> i_paddr == ADDR_W'(`PWP_OFF_CLEAR)) // RULE7
		else $error("clear decode wrong");

	set_write_a: assert property (wr_set |=> prot_q == ($past(prot_q) | ($past(i_pwdata) & $past(wmask)))) // RULE8
		else $error("set write wrong");

	unmapped_err_a: assert property (s_access_start ##0 (sel == PWP_SEL_NONE) |=> pslverr_q && pready_q)
		else $error("unmapped access not flagged");

	////////////////////////////////////////////////////////////////////////////
	// write effects judged one cycle after the landing edge, then bit 23 and output mapping, with plain bit numbers

	idle_stable_a: assert property (!(wr_clear || wr_set) |=> $stable(prot_q)) // RULE1
		else $error("protection changed without a write");

	clear_others_a: assert property (wr_clear |=> ((prot_q ^ $past(prot_q)) & ~$past(i_pwdata)) == 32'h0000_0000) // RULE2
		else $error("clear touched an unwritten bit");

	clear_down_a: assert property (wr_clear |=> (prot_q & ~$past(prot_q)) == 32'h0000_0000) // RULE2
		else $error("clear raised a protection bit");

	set_up_a: assert property (wr_set |=> ($past(prot_q) & ~prot_q) == 32'h0000_0000) // RULE8
		else $error("set dropped a protection bit");

	set_others_a: assert property (wr_set |=> ((prot_q ^ $past(prot_q)) & ~$past(i_pwdata)) == 32'h0000_0000) // RULE1
		else $error("set touched an unwritten bit");

	keep_bit23_a: assert property (prot_q[23] == 1'b1) // RULE6 RULE7
		else $error("reset bit 23 lost");

	serial_map_a: assert property (o_serial_module_protect == prot_q[7:2]) // RULE5
		else $error("serial mapping wrong");

	analog_map_a: assert property ({o_touch_ctrl_protect, o_dac_protect, o_comparator_protect, o_adc_protect} == prot_q[19:16]) // RULE4
		else $error("analog mapping wrong");

	event_map_a: assert property (o_event_system_protect == prot_q[1]) // RULE4
		else $error("event mapping wrong");

	// handshake shape: a stuck ready would complete every following transfer at once
	ready_pulse_a: assert property (pready_q |=> !pready_q)
		else $error("pready longer than one cycle");

	err_with_ready_a: assert property (pslverr_q |-> pready_q)
		else $error("pslverr without pready");

	write_data_zero_a: assert property (done && i_pwrite |-> prdata_q == 32'h0000_0000)
		else $error("read data not zero on write");

	unmapped_keep_a: assert property (done && (sel == PWP_SEL_NONE) |=> $stable(prot_q)) // RULE1
		else $error("unmapped access changed protection");

endmodule : pwp_top
